// >>> csgs_gamut_cfg.sv
// decodes gamut-compression word into effective modes
// assumes the word is a stable register; output is combinational
`timescale 1ns/100ps
`include "csgs_regs.svh"
module csgs_gamut_cfg (
  // configuration
  input wire logic [31:0] gamut_word,
  input wire logic gc_enable,
  input wire logic in_is422,
  // decoded
  output logic xv_active,
  output logic f444_444,
  output logic f422_444,
  output logic f444_422,
  output logic modes_valid,
  output csgs_pkg::csgs_fmode_t dev_mode,
  output csgs_pkg::csgs_fmode_t dark_mode,
  output csgs_pkg::csgs_fmode_t scale_mode
);
  function automatic csgs_pkg::csgs_fmode_t fmode(input logic [1:0] v);
    // reserved code falls back to average
    fmode = (v == 2'h3) ? csgs_pkg::CSGS_FAVG : csgs_pkg::csgs_fmode_t'(v);
  endfunction : fmode

  always_comb begin
    xv_active = gc_enable && gamut_word[`CSGS_B_XV_EN];
    f444_444 = gamut_word[`CSGS_B_F444_444];
    f422_444 = gamut_word[`CSGS_B_F422_444];
    f444_422 = gamut_word[`CSGS_B_F444_422];
    modes_valid = (in_is422 && !f444_422) || (!in_is422 && f422_444);
    dev_mode = modes_valid ? fmode(gamut_word[27:26])
                           : csgs_pkg::CSGS_FAVG;
    dark_mode = modes_valid ? fmode(gamut_word[25:24])
                            : csgs_pkg::CSGS_FAVG;
    scale_mode = modes_valid ? fmode(gamut_word[23:22])
                             : csgs_pkg::CSGS_FAVG;
  end
endmodule : csgs_gamut_cfg

// >>> csgs_pipe_model.sv
// pipeline partner: pixel sample source and result sink
// assumes the block's valid/ready pixel handshake on pclk
`timescale 1ns/100ps
module csgs_pipe_model (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // bench control
  input wire logic stall,
  input wire logic fmt_422,
  // source side
  output logic in_valid,
  input wire logic in_ready,
  output logic [45:0] in_pix,
  output logic in_is422,
  // sink side
  input wire logic out_valid,
  output logic out_ready,
  input wire logic [45:0] out_pix
);
  logic [45:0] src_q[$];
  logic [45:0] got_q[$];
  assign out_ready = !stall;
  assign in_is422 = fmt_422;
  task automatic push(input logic [45:0] p);
    src_q.push_back(p);
  endtask : push
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      in_valid <= 1'b0;
      in_pix <= '1;
    end else begin
      if (out_valid && !stall)
        got_q.push_back(out_pix);
      if (!in_valid || in_ready) begin
        if (src_q.size() > 0) begin
          in_valid <= 1'b1;
          in_pix <= src_q.pop_front();
        end else begin
          in_valid <= 1'b0;
          // idle data toggles so a stale sample can never look valid
          in_pix <= ~in_pix;
        end
      end
    end
  end
endmodule : csgs_pipe_model

// >>> csgs_pkg.sv
// types shared by the colour-state block
package csgs_pkg;
  typedef logic signed [12:0] csgs_coef_t;
  typedef logic signed [9:0] csgs_ofs_t;
  typedef enum logic [1:0] {
    CSGS_FMIN = 2'h0,
    CSGS_FMAX = 2'h1,
    CSGS_FAVG = 2'h2,
    CSGS_FRSV = 2'h3
  } csgs_fmode_t;
  typedef struct packed {
    logic [9:0] ch0;
    logic [9:0] ch1;
    logic [9:0] ch2;
    logic [15:0] alpha;
    logic is422;
  } csgs_pix_t;
endpackage : csgs_pkg

// >>> csgs_regs.svh
// register map, field positions and reset values of the colour-state block
// assumes 32-bit apb words, one register per aligned word
`ifndef CSGS_REGS_SVH
`define CSGS_REGS_SVH

`define CSGS_A_CTRL 12'h000
`define CSGS_A_COEF01 12'h004
`define CSGS_A_COEF23 12'h008
`define CSGS_A_COEF45 12'h00C
`define CSGS_A_COEF67 12'h010
`define CSGS_A_COEF8 12'h014
`define CSGS_A_OFS1 12'h018
`define CSGS_A_OFS2 12'h01C
`define CSGS_A_OFS3 12'h020
`define CSGS_A_ALPHA 12'h024
`define CSGS_A_GAMUT 12'h028
`define CSGS_A_STATUS 12'h02C

`define CSGS_B_XFORM_EN 0
`define CSGS_B_OUT_OFS 1
`define CSGS_B_IN_OFS 2
`define CSGS_B_GC_EN 3
`define CSGS_B_ALPHA_SEL 16
`define CSGS_B_XV_EN 31
`define CSGS_B_F444_444 30
`define CSGS_B_F422_444 29
`define CSGS_B_F444_422 28
`define CSGS_B_SAT_OVR 4

`define CSGS_CTRL_RST 32'h0000_0000
`define CSGS_COEF01_RST 32'h0000_2000
`define CSGS_COEF23_RST 32'h0000_0000
`define CSGS_COEF45_RST 32'h0000_0400
`define CSGS_COEF67_RST 32'h0000_0000
`define CSGS_COEF8_RST 32'h0000_04B4
`define CSGS_GAMUT_RST 32'h8A80_0000
`define CSGS_UNITY 13'h0400
`define CSGS_MODE_AVG 2'h2

`endif

// >>> csgs_skid_buf.sv
// two-entry buffer on the pixel path
// assumes one clock, async active-low reset
`timescale 1ns/100ps
module csgs_skid_buf (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // channels
  csgs_stream_if.snk up,
  csgs_stream_if.src dn
);
  csgs_pkg::csgs_pix_t mem_r [2];
  csgs_pkg::csgs_pix_t mem_nxt [2];
  logic [1:0] cnt_r, cnt_nxt;
  logic wr_ptr_r, wr_ptr_nxt, rd_ptr_r, rd_ptr_nxt;
  logic push, pop;

  assign up.ready = (cnt_r != 2'h2);
  assign dn.valid = (cnt_r != 2'h0);
  assign dn.data = mem_r[rd_ptr_r];

  always_comb begin
    push = up.valid && up.ready;
    pop = dn.valid && dn.ready;
    mem_nxt = mem_r;
    if (push) begin
      mem_nxt[wr_ptr_r] = up.data;
    end
    wr_ptr_nxt = wr_ptr_r ^ push;
    rd_ptr_nxt = rd_ptr_r ^ pop;
    cnt_nxt = cnt_r + {1'b0, push} - {1'b0, pop};
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r <= 2'h0;
      wr_ptr_r <= 1'b0;
      rd_ptr_r <= 1'b0;
      mem_r[0] <= '0;
      mem_r[1] <= '0;
    end else begin
      cnt_r <= cnt_nxt;
      wr_ptr_r <= wr_ptr_nxt;
      rd_ptr_r <= rd_ptr_nxt;
      mem_r <= mem_nxt;
    end
  end

  never_over_a: assert property (@(posedge pclk) disable iff (!presetn)
    cnt_r <= 2'h2) else $error("buffer count above two");
  full_stall_a: assert property (@(posedge pclk) disable iff (!presetn)
    (cnt_r == 2'h2 && !dn.ready) |=> !up.ready)
    else $error("full buffer accepted a word");
  full_cov: cover property (@(posedge pclk) disable iff (!presetn)
    cnt_r == 2'h2);
endmodule : csgs_skid_buf

// >>> csgs_stream_if.sv
// valid/ready pixel channel between the block's modules
`timescale 1ns/100ps
interface csgs_stream_if;
  logic valid;
  logic ready;
  csgs_pkg::csgs_pix_t data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface : csgs_stream_if

// >>> csgs_top.sv
// colour-space conversion and gamut state block with apb registers
// assumes pixel inputs synchronous to pclk; apb slave, zero wait states
// Overview of operation
// - input offsets applied only when enabled
// - output offsets added only when enabled
// - coefficients signed S2.10, 1024 is unity
// - per-channel 10-bit signed input/output offsets
// - alpha from message or stored alpha field
// - bit 31 enables extended gamut decode/encode
// - that enable needs gamut compression on
// - deviation factor mode, 11b reserved
// - dark factor mode, 11b reserved
// - scale factor mode, 11b reserved
//
// The APB slave port and the register offsets are this design's own decisions.
`timescale 1ns/100ps
`include "csgs_regs.svh"
module csgs_top (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // pixel input
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [9:0] in_ch0,
  input wire logic [9:0] in_ch1,
  input wire logic [9:0] in_ch2,
  input wire logic [15:0] in_alpha,
  input wire logic in_is422,
  // pixel output
  output logic out_valid,
  input wire logic out_ready,
  output logic [9:0] out_ch0,
  output logic [9:0] out_ch1,
  output logic [9:0] out_ch2,
  output logic [15:0] out_alpha,
  // decoded gamut state
  output logic xv_active,
  output logic f444_444,
  output logic f422_444,
  output logic f444_422,
  output logic gamut_modes_valid,
  output logic [1:0] dev_mode,
  output logic [1:0] dark_mode,
  output logic [1:0] scale_mode
);
  logic [31:0] ctrl_r, ctrl_nxt;
  logic [31:0] coef_r [5];
  logic [31:0] coef_nxt [5];
  logic [31:0] ofs_r [3];
  logic [31:0] ofs_nxt [3];
  logic [31:0] alpha_r, alpha_nxt, gamut_r, gamut_nxt;
  logic [31:0] pix_cnt_r, pix_cnt_nxt;
  logic [31:0] rdata;
  logic wr_en, rd_hit;
  logic [9:0] r0, r1, r2;
  logic [15:0] ra;
  csgs_pkg::csgs_fmode_t dm, km, sm;

  csgs_stream_if stage ();
  csgs_stream_if outs ();

  function automatic logic [9:0] clamp10(input logic signed [27:0] v);
    if (v < 0) clamp10 = 10'h000;
    else if (v > 28'sh0_0003FF) clamp10 = 10'h3FF;
    else clamp10 = v[9:0];
  endfunction : clamp10

  // headroom bit: a full-scale sample plus a positive offset exceeds 1023
  function automatic logic signed [11:0] in_adj(input logic [9:0] s,
                                                input logic [31:0] o,
                                                input logic en);
    in_adj = en ? $signed({2'b00, s}) + $signed({{2{o[9]}}, o[9:0]})
                : $signed({2'b00, s});
  endfunction : in_adj

  function automatic logic signed [27:0] dot3(input logic signed [11:0] a,
    input logic signed [11:0] b, input logic signed [11:0] c,
    input logic [12:0] k0, input logic [12:0] k1, input logic [12:0] k2);
    logic signed [27:0] s;
    // operands widened first, else each product is cut to 13 bits
    s = 28'(a) * 28'($signed(k0)) + 28'(b) * 28'($signed(k1))
      + 28'(c) * 28'($signed(k2));
    dot3 = s >>> 10;
  endfunction : dot3

  // apb: zero wait states, all addresses answered
  assign pready = 1'b1;
  assign pslverr = 1'b0;
  assign wr_en = psel && penable && pwrite;

  always_comb begin
    rd_hit = 1'b1;
    case (paddr)
      `CSGS_A_CTRL: rdata = ctrl_r;
      `CSGS_A_COEF01: rdata = coef_r[0];
      `CSGS_A_COEF23: rdata = coef_r[1];
      `CSGS_A_COEF45: rdata = coef_r[2];
      `CSGS_A_COEF67: rdata = coef_r[3];
      `CSGS_A_COEF8: rdata = coef_r[4];
      `CSGS_A_OFS1: rdata = ofs_r[0];
      `CSGS_A_OFS2: rdata = ofs_r[1];
      `CSGS_A_OFS3: rdata = ofs_r[2];
      `CSGS_A_ALPHA: rdata = alpha_r;
      `CSGS_A_GAMUT: rdata = gamut_r;
      `CSGS_A_STATUS: rdata = pix_cnt_r;
      default: begin
        rd_hit = 1'b0;
        rdata = 32'h0000_0000;
      end
    endcase
    prdata = rd_hit ? rdata : 32'h0000_0000;
  end

  always_comb begin
    ctrl_nxt = ctrl_r;
    coef_nxt = coef_r;
    ofs_nxt = ofs_r;
    alpha_nxt = alpha_r;
    gamut_nxt = gamut_r;
    if (wr_en) begin
      // reserved bits are not stored and read back zero
      case (paddr)
        `CSGS_A_CTRL: ctrl_nxt = pwdata & 32'h0000_000F;
        `CSGS_A_COEF01: coef_nxt[0] = pwdata & 32'h1FFF_FFF8;
        `CSGS_A_COEF23: coef_nxt[1] = pwdata & 32'h03FF_FFFF;
        `CSGS_A_COEF45: coef_nxt[2] = pwdata & 32'h03FF_FFFF;
        `CSGS_A_COEF67: coef_nxt[3] = pwdata & 32'h03FF_FFFF;
        `CSGS_A_COEF8: coef_nxt[4] = pwdata & 32'h0000_1FFF;
        `CSGS_A_OFS1: ofs_nxt[0] = pwdata & 32'h000F_FFFF;
        `CSGS_A_OFS2: ofs_nxt[1] = pwdata & 32'h000F_FFFF;
        `CSGS_A_OFS3: ofs_nxt[2] = pwdata & 32'h000F_FFFF;
        `CSGS_A_ALPHA: alpha_nxt = pwdata & 32'h0001_FFFF;
        // override bit kept as written; software must write zero
        `CSGS_A_GAMUT: gamut_nxt = pwdata & 32'hFFC0_0010;
        default: ctrl_nxt = ctrl_r;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r <= `CSGS_CTRL_RST;
      coef_r[0] <= `CSGS_COEF01_RST;
      coef_r[1] <= `CSGS_COEF23_RST;
      coef_r[2] <= `CSGS_COEF45_RST;
      coef_r[3] <= `CSGS_COEF67_RST;
      coef_r[4] <= `CSGS_COEF8_RST;
      ofs_r[0] <= 32'h0000_0000;
      ofs_r[1] <= 32'h0000_0000;
      ofs_r[2] <= 32'h0000_0000;
      alpha_r <= 32'h0000_0000;
      gamut_r <= `CSGS_GAMUT_RST;
    end else begin
      ctrl_r <= ctrl_nxt;
      coef_r <= coef_nxt;
      ofs_r <= ofs_nxt;
      alpha_r <= alpha_nxt;
      gamut_r <= gamut_nxt;
    end
  end

  // conversion arithmetic, one registered stage into the buffer
  always_comb begin
    logic signed [11:0] a0, a1, a2;
    logic ien;
    ien = ctrl_r[`CSGS_B_IN_OFS];
    a0 = in_adj(in_ch0, ofs_r[0], ien);
    a1 = in_adj(in_ch1, ofs_r[1], ien);
    a2 = in_adj(in_ch2, ofs_r[2], ien);
    if (ctrl_r[`CSGS_B_XFORM_EN]) begin
      r0 = clamp10(dot3(a0, a1, a2, coef_r[0][15:3], coef_r[0][28:16],
                        coef_r[1][12:0])
        + (ctrl_r[`CSGS_B_OUT_OFS] ? 28'(signed'(ofs_r[0][19:10])) : 28'sd0));
      r1 = clamp10(dot3(a0, a1, a2, coef_r[1][25:13], coef_r[2][12:0],
                        coef_r[2][25:13])
        + (ctrl_r[`CSGS_B_OUT_OFS] ? 28'(signed'(ofs_r[1][19:10])) : 28'sd0));
      r2 = clamp10(dot3(a0, a1, a2, coef_r[3][12:0], coef_r[3][25:13],
                        coef_r[4][12:0])
        + (ctrl_r[`CSGS_B_OUT_OFS] ? 28'(signed'(ofs_r[2][19:10])) : 28'sd0));
    end else begin
      r0 = in_ch0;
      r1 = in_ch1;
      r2 = in_ch2;
    end
    ra = alpha_r[`CSGS_B_ALPHA_SEL] ? alpha_r[15:0] : in_alpha;
  end

  logic st_valid_r, st_valid_nxt;
  csgs_pkg::csgs_pix_t st_data_r, st_data_nxt;
  assign in_ready = !st_valid_r || stage.ready;
  assign stage.valid = st_valid_r;
  assign stage.data = st_data_r;

  always_comb begin
    st_valid_nxt = st_valid_r;
    st_data_nxt = st_data_r;
    pix_cnt_nxt = pix_cnt_r;
    if (in_ready) begin
      st_valid_nxt = in_valid;
      if (in_valid) begin
        st_data_nxt = '{ch0: r0, ch1: r1, ch2: r2, alpha: ra,
                        is422: in_is422};
        pix_cnt_nxt = pix_cnt_r + 32'h0000_0001;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_valid_r <= 1'b0;
      st_data_r <= '0;
      pix_cnt_r <= 32'h0000_0000;
    end else begin
      st_valid_r <= st_valid_nxt;
      st_data_r <= st_data_nxt;
      pix_cnt_r <= pix_cnt_nxt;
    end
  end

  csgs_skid_buf u_buf (
    .pclk(pclk),
    .presetn(presetn),
    .up(stage.snk),
    .dn(outs.src)
  );

  assign out_valid = outs.valid;
  assign outs.ready = out_ready;
  assign out_ch0 = outs.data.ch0;
  assign out_ch1 = outs.data.ch1;
  assign out_ch2 = outs.data.ch2;
  assign out_alpha = outs.data.alpha;

  csgs_gamut_cfg u_gamut (
    .gamut_word(gamut_r),
    .gc_enable(ctrl_r[`CSGS_B_GC_EN]),
    .in_is422(in_is422),
    .xv_active(xv_active),
    .f444_444(f444_444),
    .f422_444(f422_444),
    .f444_422(f444_422),
    .modes_valid(gamut_modes_valid),
    .dev_mode(dm),
    .dark_mode(km),
    .scale_mode(sm)
  );
  assign dev_mode = dm;
  assign dark_mode = km;
  assign scale_mode = sm;

  // properties
  pass_through_a: assert property (@(posedge pclk) disable iff (!presetn)
    (in_valid && in_ready && !ctrl_r[`CSGS_B_XFORM_EN])
    |=> st_data_r.ch0 == $past(in_ch0))
    else $error("disabled transform altered sample");
  alpha_state_a: assert property (@(posedge pclk) disable iff (!presetn)
    (in_valid && in_ready && alpha_r[`CSGS_B_ALPHA_SEL])
    |=> st_data_r.alpha == $past(alpha_r[15:0]))
    else $error("alpha not taken from state");
  alpha_msg_a: assert property (@(posedge pclk) disable iff (!presetn)
    (in_valid && in_ready && !alpha_r[`CSGS_B_ALPHA_SEL])
    |=> st_data_r.alpha == $past(in_alpha))
    else $error("alpha not taken from message");
  unity_copy_a: assert property (@(posedge pclk) disable iff (!presetn)
    (in_valid && in_ready && ctrl_r[2:0] == 3'h1
     && coef_r[0][15:3] == `CSGS_UNITY && coef_r[0][28:16] == 13'h0000
     && coef_r[1][12:0] == 13'h0000)
    |=> st_data_r.ch0 == $past(in_ch0))
    else $error("unity coefficient not unity");
  xv_gate_a: assert property (@(posedge pclk) disable iff (!presetn)
    !ctrl_r[`CSGS_B_GC_EN] |-> !xv_active)
    else $error("extended gamut on without compression");
  xv_follow_a: assert property (@(posedge pclk) disable iff (!presetn)
    ctrl_r[`CSGS_B_GC_EN] |-> xv_active == gamut_r[`CSGS_B_XV_EN])
    else $error("extended gamut enable not followed");
  mode_rsv_a: assert property (@(posedge pclk) disable iff (!presetn)
    dev_mode != 2'h3 && dark_mode != 2'h3 && scale_mode != 2'h3)
    else $error("reserved factor mode leaked");
  mode_gate_a: assert property (@(posedge pclk) disable iff (!presetn)
    !gamut_modes_valid |-> dev_mode == `CSGS_MODE_AVG)
    else $error("factor mode used outside valid input");
  ofs_off_a: assert property (@(posedge pclk) disable iff (!presetn)
    (in_valid && in_ready && ctrl_r[2:0] == 3'h0) |=>
    st_data_r.ch1 == $past(in_ch1))
    else $error("offsets applied while disabled");
  stage_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
    (stage.valid && !stage.ready) |=> stage.valid && $stable(st_data_r))
    else $error("stalled word changed");
  xform_cov: cover property (@(posedge pclk) disable iff (!presetn)
    in_valid && in_ready && ctrl_r[`CSGS_B_XFORM_EN]);
  stall_cov: cover property (@(posedge pclk) disable iff (!presetn)
    out_valid && !out_ready ##1 out_valid && out_ready);
  wr_cov: cover property (@(posedge pclk) disable iff (!presetn)
    wr_en && paddr == `CSGS_A_GAMUT);
endmodule : csgs_top

// >>> csgs_top_tb.sv
// bench for the colour-state block: apb tasks, pixel traffic, compares
// assumes csgs_pipe_model as the far side of the pixel path
`timescale 1ns/100ps
`include "csgs_regs.svh"
module csgs_top_tb;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, gw;
  logic in_valid, in_ready, in_is422, out_valid, out_ready;
  logic stall, fmt_422, xv, f0, f1, f2, mv;
  logic [45:0] in_pix, out_pix;
  logic [9:0] o0, o1, o2;
  logic [15:0] oa;
  logic [1:0] dm, km, sm;
  int mismatches = 0;
  int samples_checked = 0;
  int cf[9] = '{1024, 0, 0, 512, 512, 0, -1024, 0, 2048};
  int oi[3] = '{-8, 20, 4};
  int oo[3] = '{-3, 7, 500};
  logic [3:0] modes[5] = '{4'h6, 4'h1, 4'h5, 4'h3, 4'hF};
  logic [3:0] ctl;
  logic asel;
  logic [15:0] areg = 16'h0A5A;
  logic [45:0] exp_q[$];
  assign out_pix = {o0, o1, o2, oa};

  csgs_top uut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .in_valid(in_valid), .in_ready(in_ready), .in_ch0(in_pix[45:36]),
    .in_ch1(in_pix[35:26]), .in_ch2(in_pix[25:16]),
    .in_alpha(in_pix[15:0]), .in_is422(in_is422),
    .out_valid(out_valid), .out_ready(out_ready), .out_ch0(o0),
    .out_ch1(o1), .out_ch2(o2), .out_alpha(oa), .xv_active(xv),
    .f444_444(f0), .f422_444(f1), .f444_422(f2),
    .gamut_modes_valid(mv), .dev_mode(dm), .dark_mode(km),
    .scale_mode(sm));
  csgs_pipe_model u_pipe (.pclk(pclk), .presetn(presetn), .stall(stall),
    .fmt_422(fmt_422), .in_valid(in_valid), .in_ready(in_ready),
    .in_pix(in_pix), .in_is422(in_is422), .out_valid(out_valid),
    .out_ready(out_ready), .out_pix(out_pix));

  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  task automatic check(input string what, input logic [45:0] seen,
                       input logic [45:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic end_sim();
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : end_sim

  // wait states are allowed: the access phase lasts until pready
  task automatic apb_xfer(input logic wr, input logic [11:0] a,
                          input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 50)
      mismatches++;
  endtask : apb_xfer

  task automatic apb_wr(input logic [11:0] a, input logic [31:0] d);
    apb_xfer(1'b1, a, d);
  endtask : apb_wr

  task automatic rd_chk(input logic [11:0] a, input logic [31:0] e,
                        input string name);
    apb_xfer(1'b0, a, 32'h0000_0000);
    check(name, 46'(rd), 46'(e));
  endtask : rd_chk

  task automatic set_gamut(input logic [31:0] g);
    gw = g;
    apb_wr(`CSGS_A_GAMUT, g);
  endtask : set_gamut

  task automatic gam_chk();
    logic v;
    logic [1:0] e[3];
    @(negedge pclk);
    v = (fmt_422 & !gw[28]) | (!fmt_422 & gw[29]);
    for (int i = 0; i < 3; i++) begin
      e[i] = gw[27-2*i -: 2];
      if (!v || e[i] == 2'h3)
        e[i] = 2'h2;
    end
    check("gamut", 46'({xv, f0, f1, f2, mv, dm, km, sm}),
          46'({ctl[3] & gw[31], gw[30:28], v, e[0], e[1], e[2]}));
  endtask : gam_chk

  task automatic load_cfg();
    apb_wr(`CSGS_A_COEF01, {3'h0, 13'(cf[1]), 13'(cf[0]), 3'h0});
    apb_wr(`CSGS_A_COEF23, {6'h0, 13'(cf[3]), 13'(cf[2])});
    apb_wr(`CSGS_A_COEF45, {6'h0, 13'(cf[5]), 13'(cf[4])});
    apb_wr(`CSGS_A_COEF67, {6'h0, 13'(cf[7]), 13'(cf[6])});
    apb_wr(`CSGS_A_COEF8, {19'h0, 13'(cf[8])});
    for (int k = 0; k < 3; k++)
      apb_wr(`CSGS_A_OFS1 + 12'(4 * k), {12'h0, 10'(oo[k]), 10'(oi[k])});
    apb_wr(`CSGS_A_ALPHA, {15'h0, asel, areg});
    apb_wr(`CSGS_A_CTRL, {28'h0, ctl});
  endtask : load_cfg

  function automatic logic [45:0] expect_pix(input logic [45:0] p);
    int v[3];
    int s;
    logic [29:0] o;
    for (int j = 0; j < 3; j++)
      v[j] = p[45-10*j -: 10];
    for (int k = 0; k < 3; k++) begin
      s = v[k];
      if (ctl[0]) begin
        s = 0;
        for (int j = 0; j < 3; j++)
          s += cf[3*k+j] * (v[j] + (ctl[2] ? oi[j] : 0));
        s = s >>> 10;
        s += ctl[1] ? oo[k] : 0;
        s = s < 0 ? 0 : (s > 1023 ? 1023 : s);
      end
      o[29-10*k -: 10] = s[9:0];
    end
    return {o, asel ? areg : p[15:0]};
  endfunction : expect_pix

  task automatic send(input logic [45:0] p);
    u_pipe.push(p);
    exp_q.push_back(expect_pix(p));
  endtask : send

  task automatic drain();
    int n;
    logic [45:0] e;
    n = 0;
    while (u_pipe.got_q.size() < exp_q.size() && n < 200) begin
      @(posedge pclk);
      n++;
    end
    if (n >= 200)
      mismatches++;
    while (exp_q.size() > 0) begin
      e = exp_q.pop_front();
      check("pixel", u_pipe.got_q.pop_front(), e);
    end
  endtask : drain

  initial begin
    #200000;
    mismatches++;
    end_sim();
  end

  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    stall = 1'b0;
    fmt_422 = 1'b1;
    ctl = 4'h0;
    asel = 1'b0;
    gw = 32'h8A80_0000;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    rd_chk(`CSGS_A_CTRL, 32'h0000_0000, "ctrl");
    rd_chk(`CSGS_A_COEF01, 32'h0000_2000, "coef01");
    rd_chk(`CSGS_A_COEF45, 32'h0000_0400, "coef45");
    rd_chk(`CSGS_A_COEF8, 32'h0000_04B4, "coef8");
    rd_chk(`CSGS_A_GAMUT, 32'h8A80_0000, "gamut word");
    gam_chk();
    for (int m = 0; m < 4; m++) begin
      set_gamut({4'h8, 2'(m), 2'(m), 2'(m), 22'h0});
      gam_chk();
    end
    set_gamut(32'h9000_0000);
    gam_chk();
    fmt_422 <= 1'b0;
    set_gamut(32'h6400_0000);
    gam_chk();
    set_gamut(32'h0400_0000);
    gam_chk();
    ctl = 4'h8;
    apb_wr(`CSGS_A_CTRL, 32'h0000_0008);
    set_gamut(32'h8000_0000);
    gam_chk();
    set_gamut(32'h0000_0000);
    gam_chk();
    set_gamut(32'hFFFF_FFE0);
    rd_chk(`CSGS_A_GAMUT, 32'hFFC0_0000, "gamut mbz");
    for (int t = 0; t < 5; t++) begin
      ctl = modes[t];
      asel = t[0];
      load_cfg();
      send({10'd200, 10'd100, 10'd50, 16'h1234});
      send({10'd1000, 10'd6, 10'd900, 16'hBEEF});
      drain();
    end
    // far side stalls: stage and both buffer entries fill, nothing lost
    stall <= 1'b1;
    for (int k = 0; k < 4; k++)
      send({10'(100 * k + 2), 10'(10 * k), 10'(998 - 2 * k), 16'(k)});
    repeat (12) @(posedge pclk);
    @(negedge pclk);
    check("in_ready", 46'(in_ready), 46'(0));
    check("held", 46'(u_pipe.got_q.size()), 46'(0));
    @(posedge pclk);
    stall <= 1'b0;
    drain();
    rd_chk(`CSGS_A_STATUS, 32'd14, "count");
    apb_wr(`CSGS_A_STATUS, 32'hFFFF_FFFF);
    rd_chk(`CSGS_A_STATUS, 32'd14, "count ro");
    apb_wr(12'h100, 32'hFFFF_FFFF);
    rd_chk(12'h100, 32'h0000_0000, "unmapped");
    check("pslverr", 46'(pslverr), 46'(0));
    end_sim();
  end
endmodule : csgs_top_tb
